// >>> rtl/epp_pkg.sv
// Constants shared by the parallel port cycle engine and its helpers.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package epp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_CONTROL = 4'h2;
  localparam logic [3:0] IDX_EPP_ADDR = 4'h3;
  localparam logic [3:0] IDX_EPP_DATA0 = 4'h4;
  localparam logic [3:0] IDX_EPP_DATA3 = 4'h7;
  localparam logic [3:0] IDX_MODE = 4'h8;
  localparam int ADDR_W = 6;

  // Control register fields
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELIN = 3;
  localparam int CTL_IRQE = 4;
  localparam int CTL_PCD = 5;
  localparam int CTL_W = 6;
  localparam logic [5:0] CTL_RESET = 6'h00;

  // Status register fields
  localparam int STS_TIMEOUT = 0;

  // Mode register fields
  localparam int MODE_EPP = 0;
  localparam int MODE_19 = 1;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // Synchroniser vector layout
  localparam int SY_WAIT = 0;
  localparam int SY_PERIPHERAL_INTERRUPT = 1;
  localparam int SY_PE = 2;
  localparam int SY_SLCT = 3;
  localparam int SY_ERR = 4;
  localparam int SY_BUSY = 5;
  localparam int SY_PD = 6;
  localparam int SY_W = 14;

  // Watchdog timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WDT_TIME_NS = 10000;
  localparam int WDT_CYCLES_I = (WDT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] WDT_CYCLES = WDT_CYCLES_I[10:0];

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Handshake states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_STROBE = 2'b10,
    ST_DONE = 2'b11
  } cyc_state_type;

endpackage

// >>> rtl/bit_sync.sv
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherence across bits.
module bit_sync
  import epp_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // First stage, read only by the second stage
  logic [W-1:0] meta_q;

  // One pair of flops per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (srst) begin
          meta_q[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

// >>> rtl/epp_cycle_engine.sv
// Enhanced parallel port cycle engine with its register file.
// Assumes an AXI4-Lite master on mclk and a peripheral on the cable pins.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
module epp_cycle_engine
  import epp_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_data_in,
  output logic [7:0] port_data_out,
  output logic port_data_oe,
  output logic write_direction_n,
  output logic data_strobe_n,
  output logic address_strobe_n,
  output logic peripheral_reset_n,
  input wire logic peripheral_wait_n,
  input wire logic peripheral_interrupt,
  input wire logic paper_end,
  input wire logic printer_selected,
  input wire logic printer_error_n,
  input wire logic printer_busy,
  output logic interrupt_out
);

  // True for the address port and the four data ports
  function automatic logic is_epp_port(input logic [3:0] idx);
    return (idx >= IDX_EPP_ADDR) && (idx <= IDX_EPP_DATA3);
  endfunction

  // True for any index that holds a register
  function automatic logic is_mapped(input logic [3:0] idx);
    return idx <= IDX_MODE;
  endfunction

  // Synchronised pin levels
  logic [SY_W-1:0] sync_s;
  logic wait_s; // Peripheral wait, high = not waiting
  logic [7:0] pd_s; // Cable data bus as seen in the clock domain

  // Register file
  logic [7:0] data_q; // Shared data/address latch, drives the cable
  logic [CTL_W-1:0] ctrl_q; // Control register bits 0..5
  logic [1:0] mode_q; // Enhanced enable and protocol select
  logic timeout_q; // Sticky watchdog flag
  logic [7:0] capture_q; // Byte caught at the end of a read

  // Bus slave holding registers
  logic aw_have_q;
  logic w_have_q;
  logic ar_have_q;
  logic [3:0] aw_idx_q;
  logic [3:0] ar_idx_q;
  logic [7:0] w_byte_q;
  logic w_lane_q; // Low byte lane enabled

  // Handshake engine
  cyc_state_type state_q, state_d;
  logic cyc_read_q; // Cycle direction, high = read
  logic cyc_addr_q; // Cycle targets the address port
  logic [10:0] wdt_q; // Watchdog cycle count
  logic wdt_fire; // Watchdog reached its limit

  // Decode of what the bus wants this cycle
  logic wr_go; // A write is accepted for action
  logic rd_go; // A read is accepted for action
  logic wr_epp; // The write starts a cable cycle
  logic rd_epp; // The read starts a cable cycle
  logic reg_we; // Plain register write strobe
  logic start_cyc; // Cable cycle begins

  // Pin synchronisers, wait first
  bit_sync #(
    .W(SY_W)
  ) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in({port_data_in, printer_busy, printer_error_n, printer_selected,
      paper_end, peripheral_interrupt, peripheral_wait_n}),
    .sync_out(sync_s)
  );

  assign wait_s = sync_s[SY_WAIT];
  assign pd_s = sync_s[SY_PD +: 8];

  // Only one action at a time; writes win a tie with reads
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid && (state_q == ST_IDLE);
  assign rd_go = ar_have_q && !wr_go && !s_axi_rvalid && (state_q == ST_IDLE);
  assign wr_epp = wr_go && is_epp_port(aw_idx_q) && mode_q[MODE_EPP] && w_lane_q;
  assign rd_epp = rd_go && is_epp_port(ar_idx_q) && mode_q[MODE_EPP];
  assign reg_we = wr_go && !wr_epp && w_lane_q;
  assign start_cyc = wr_epp || rd_epp;
  assign wdt_fire = (wdt_q >= WDT_CYCLES);

  // Write address channel
  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_have_q <= 1'b0;
      aw_idx_q <= 4'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      if (wr_go) begin
        aw_have_q <= 1'b0;
      end else if (s_axi_awvalid && !aw_have_q && !s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Write data channel, only the low lane carries a register
  always_ff @(posedge mclk) begin
    if (srst) begin
      w_have_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= 1'b0;
      if (wr_go) begin
        w_have_q <= 1'b0;
      end else if (s_axi_wvalid && !w_have_q && !s_axi_wready) begin
        w_have_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read address channel
  always_ff @(posedge mclk) begin
    if (srst) begin
      ar_have_q <= 1'b0;
      ar_idx_q <= 4'h0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= 1'b0;
      if (rd_go) begin
        ar_have_q <= 1'b0;
      end else if (s_axi_arvalid && !ar_have_q && !s_axi_arready) begin
        ar_have_q <= 1'b1;
        ar_idx_q <= s_axi_araddr[ADDR_W-1:2];
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Write response; a cable write is only answered when it ends
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (s_axi_bvalid) begin
      // Answer stands until the master takes it
      if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end else if (state_q == ST_DONE && !cyc_read_q) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go && !wr_epp) begin
      // Plain register, unmapped, or cable port outside enhanced mode or with the low lane off
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (is_mapped(aw_idx_q) && !is_epp_port(aw_idx_q)) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read response; a cable read is stretched until the byte is caught
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (state_q == ST_DONE && cyc_read_q) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= {24'h000000, capture_q};
    end else if (rd_go && !rd_epp) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (is_mapped(ar_idx_q) && !is_epp_port(ar_idx_q)) ? RESP_OKAY : RESP_SLVERR;
      unique case (ar_idx_q)
        // Input direction reads the cable, output reads the latch
        IDX_DATA: s_axi_rdata <= {24'h000000, ctrl_q[CTL_PCD] ? pd_s : data_q};
        IDX_STATUS: s_axi_rdata <= {24'h000000, !sync_s[SY_BUSY], sync_s[SY_PERIPHERAL_INTERRUPT],
          sync_s[SY_PE], sync_s[SY_SLCT], sync_s[SY_ERR], 2'b00, timeout_q};
        IDX_CONTROL: s_axi_rdata <= {26'h0000000, ctrl_q};
        IDX_MODE: s_axi_rdata <= {30'h00000000, mode_q};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Shared data latch; one register serves both port styles
  always_ff @(posedge mclk) begin
    if (srst) begin
      data_q <= 8'h00;
    end else if (wr_epp || (reg_we && aw_idx_q == IDX_DATA)) begin
      data_q <= w_byte_q;
    end
  end

  // Control register; direction bit lives at bit 5
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= CTL_RESET;
    end else if (reg_we && aw_idx_q == IDX_CONTROL) begin
      ctrl_q <= w_byte_q[CTL_W-1:0];
    end
  end

  // Mode register selects enhanced mode and protocol revision
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q <= MODE_RESET;
    end else if (reg_we && aw_idx_q == IDX_MODE) begin
      mode_q <= w_byte_q[1:0];
    end
  end

  // Timeout flag; a new timeout beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      timeout_q <= 1'b0;
    end else if ((state_q == ST_ARM || state_q == ST_STROBE) && wdt_fire) begin
      timeout_q <= 1'b1;
    end else if (reg_we && aw_idx_q == IDX_STATUS && w_byte_q[STS_TIMEOUT]) begin
      timeout_q <= 1'b0;
    end
  end

  // Watchdog restarts with every cycle and counts while it runs
  always_ff @(posedge mclk) begin
    if (srst) begin
      wdt_q <= 11'h000;
    end else if (start_cyc) begin
      wdt_q <= 11'h000;
    end else if ((state_q == ST_ARM || state_q == ST_STROBE) && !wdt_fire) begin
      wdt_q <= wdt_q + 11'h001;
    end
  end

  // Cycle attributes caught at start
  always_ff @(posedge mclk) begin
    if (srst) begin
      cyc_read_q <= 1'b0;
      cyc_addr_q <= 1'b0;
    end else if (start_cyc) begin
      cyc_read_q <= rd_epp;
      cyc_addr_q <= rd_epp ? (ar_idx_q == IDX_EPP_ADDR) : (aw_idx_q == IDX_EPP_ADDR);
    end
  end

  // Read byte is caught while the strobe is still on
  always_ff @(posedge mclk) begin
    if (srst) begin
      capture_q <= 8'h00;
    end else if (state_q == ST_STROBE && cyc_read_q && (wait_s || wdt_fire)) begin
      capture_q <= pd_s;
    end
  end

  // Handshake next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_cyc) begin
          // Revision 1.9 waits for the peripheral to show ready first
          state_d = (mode_q[MODE_19] && wait_s) ? ST_ARM : ST_STROBE;
        end
      end
      ST_ARM: begin
        if (wdt_fire) begin
          state_d = ST_DONE;
        end else if (!wait_s) begin
          state_d = ST_STROBE;
        end
      end
      ST_STROBE: begin
        // Wait low stalls; its rise, or the watchdog, ends the cycle
        if (wait_s || wdt_fire) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Cable pins, registered from the next state so they line up with it
  always_ff @(posedge mclk) begin
    if (srst) begin
      data_strobe_n <= 1'b1;
      address_strobe_n <= 1'b1;
      write_direction_n <= 1'b1;
      port_data_oe <= 1'b0;
      peripheral_reset_n <= 1'b0;
      port_data_out <= 8'h00;
    end else begin
      peripheral_reset_n <= ctrl_q[CTL_INIT];
      port_data_out <= wr_epp ? w_byte_q : data_q;
      if (state_d == ST_STROBE) begin
        // Strobe bit set in the control register forces write mode
        write_direction_n <= cyc_read_d() && !ctrl_q[CTL_STROBE];
        port_data_oe <= !cyc_read_d() || ctrl_q[CTL_STROBE];
        data_strobe_n <= !(state_d == ST_STROBE && !cyc_addr_d());
        address_strobe_n <= !(state_d == ST_STROBE && cyc_addr_d());
      end else if (state_d != ST_ARM) begin // Armed: lines hold as they were
        // No cycle running: plain or bidirectional port behaviour
        data_strobe_n <= !ctrl_q[CTL_STROBE];
        address_strobe_n <= !ctrl_q[CTL_SELIN];
        write_direction_n <= mode_q[MODE_EPP] ? ctrl_q[CTL_PCD] : !ctrl_q[CTL_AUTOFD];
        port_data_oe <= !ctrl_q[CTL_PCD];
      end
    end
  end

  // Direction of the cycle as it will be on the next edge
  function automatic logic cyc_read_d();
    return start_cyc ? rd_epp : cyc_read_q;
  endfunction

  // Target port of the cycle as it will be on the next edge
  function automatic logic cyc_addr_d();
    logic a;
    a = rd_epp ? (ar_idx_q == IDX_EPP_ADDR) : (aw_idx_q == IDX_EPP_ADDR);
    return start_cyc ? a : cyc_addr_q;
  endfunction

  // Interrupt pin passes through uninverted, gated by its enable
  always_ff @(posedge mclk) begin
    if (srst) begin
      interrupt_out <= 1'b0;
    end else begin
      interrupt_out <= sync_s[SY_PERIPHERAL_INTERRUPT] && ctrl_q[CTL_IRQE];
    end
  end

endmodule

// >>> dv/epp_cycle_engine_properties.sv
// Pin-level assertions for the parallel port cycle engine.
// Assumes control bits 0 and 3 stay clear, so a low strobe means a cycle.
module epp_cycle_engine_properties (
  input wire logic mclk,
  input wire logic srst,
  input wire logic data_strobe_n,
  input wire logic address_strobe_n,
  input wire logic write_direction_n,
  input wire logic port_data_oe,
  input wire logic [7:0] port_data_out,
  input wire logic peripheral_wait_n,
  input wire logic peripheral_interrupt,
  input wire logic interrupt_out,
  input wire logic peripheral_reset_n,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic stb_n; // Both strobes high
  logic [11:0] low_q; // Cycles of the current strobe
  assign stb_n = data_strobe_n & address_strobe_n;
  // Strobe length; cleared between cycles
  always_ff @(posedge mclk) begin
    if (srst || stb_n) begin
      low_q <= 12'h000;
    end else begin
      low_q <= low_q + 12'h001;
    end
  end
  property p_rst_idle;
    $fell(srst) |-> stb_n && !peripheral_reset_n && !s_axi_bvalid;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins not idle");
  property p_stall;
    !stb_n |-> !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_stall: assert property (p_stall) else $error("answer during strobe");
  property p_rd_float;
    !stb_n && write_direction_n |-> !port_data_oe;
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("bus driven in read");
  property p_wr_drive;
    !stb_n && !write_direction_n |-> port_data_oe;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("bus loose in write");
  property p_one_strobe;
    data_strobe_n || address_strobe_n;
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two strobes");
  property p_wdt;
    low_q <= 12'h3ea;
  endproperty
  a_wdt: assert property (p_wdt) else $error("strobe outlived watchdog");
  // Sync latency is short, so six low samples rule out a normal end
  property p_wait_hold;
    (!stb_n && !peripheral_wait_n) [*6] ##1 stb_n |-> low_q >= 12'h3de;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("ended while waiting");
  property p_wr_hold;
    $rose(stb_n) && !write_direction_n |=> $stable(port_data_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("byte dropped");
  property p_peripheral_interrupt;
    !peripheral_interrupt [*5] |=> !interrupt_out;
  endproperty
  a_peripheral_interrupt: assert property (p_peripheral_interrupt) else $error("spurious interrupt");
  c_addr: cover property ($fell(address_strobe_n));
  c_data: cover property ($fell(data_strobe_n));
  c_wdt: cover property (low_q == 12'h3e8);
endmodule

// >>> dv/epp_periph_model.sv
// Behavioural peripheral on the cable side of the cycle engine.
// Assumes the bench changes delay, stall and read byte between cycles.
module epp_periph_model (
  input wire logic mclk,
  input wire logic data_strobe_n,
  input wire logic address_strobe_n,
  input wire logic write_direction_n,
  input wire logic [7:0] port_data_out,
  input wire logic port_data_oe,
  input wire logic [3:0] dly,
  input wire logic hang,
  input wire logic arm_hold,
  input wire logic [7:0] rd_byte,
  output logic peripheral_wait_n,
  output logic [7:0] port_data_in,
  output logic [7:0] got_byte,
  output logic got_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stb; // Any strobe low
  logic stb_q; // Strobe one cycle ago
  logic [3:0] cnt_q; // Cycles since strobe fell
  logic drv_q; // Model drives the bus
  logic ack_q; // Wait released
  logic [7:0] last_q = 8'h00; // Last bus level
  assign stb = !(data_strobe_n && address_strobe_n);
  // Released bus toggles so a stale byte never looks valid
  assign port_data_in = port_data_oe ? port_data_out : (drv_q ? rd_byte : ~last_q);
  // Arm hold keeps wait high before a cycle
  assign peripheral_wait_n = arm_hold | ack_q;
  // Handshake: drive byte first, then release wait
  always_ff @(posedge mclk) begin
    stb_q <= stb;
    last_q <= port_data_in;
    if (!stb) begin
      cnt_q <= 4'h0;
      drv_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (cnt_q != dly) begin
      cnt_q <= cnt_q + 4'h1;
    end else if (!hang) begin
      drv_q <= write_direction_n;
      ack_q <= drv_q || !write_direction_n;
    end
    if (stb && !stb_q) begin
      got_addr <= !address_strobe_n;
    end
    if (stb_q && !stb) begin
      got_byte <= port_data_out;
    end
  end
endmodule

// >>> dv/epp_cycle_engine_tb.sv
// Self-checking bench for the parallel port cycle engine.
// Assumes a 100 MHz clock and the peripheral model on the cable pins.
module epp_cycle_engine_tb
  import epp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] port_data_in, port_data_out, got_byte, b;
  logic port_data_oe, write_direction_n, data_strobe_n, address_strobe_n;
  logic peripheral_reset_n, peripheral_wait_n, interrupt_out, got_addr;
  logic peripheral_interrupt = 1'b0, paper_end = 1'b0, printer_selected = 1'b0;
  logic printer_error_n = 1'b1, printer_busy = 1'b0;
  logic [3:0] dly = 4'h0; // Peripheral answer delay
  logic hang = 1'b0, arm_hold = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic [31:0] d;
  logic [1:0] r;
  int err_total = 0, samples_checked = 0, cycles = 0;
  time t0;
  epp_cycle_engine i_epp_cycle_engine (
    .mclk(mclk), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_data_in(port_data_in), .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .write_direction_n(write_direction_n), .data_strobe_n(data_strobe_n),
    .address_strobe_n(address_strobe_n), .peripheral_reset_n(peripheral_reset_n),
    .peripheral_wait_n(peripheral_wait_n), .peripheral_interrupt(peripheral_interrupt),
    .paper_end(paper_end), .printer_selected(printer_selected),
    .printer_error_n(printer_error_n), .printer_busy(printer_busy), .interrupt_out(interrupt_out)
  );
  epp_periph_model i_epp_periph_model (
    .mclk(mclk), .data_strobe_n(data_strobe_n), .address_strobe_n(address_strobe_n),
    .write_direction_n(write_direction_n), .port_data_out(port_data_out),
    .port_data_oe(port_data_oe), .dly(dly), .hang(hang), .arm_hold(arm_hold),
    .rd_byte(rd_byte), .peripheral_wait_n(peripheral_wait_n), .port_data_in(port_data_in),
    .got_byte(got_byte), .got_addr(got_addr)
  );
  always #5 mclk = ~mclk;
  // Ceiling: the one watchdog run and the traffic fit well inside it
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register write; address and data offered together
  task automatic axw(input logic [5:0] a, input logic [7:0] v, output logic [1:0] rs);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Register read
  task automatic axr(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Write that must be accepted
  task automatic wrk(input logic [5:0] a, input logic [7:0] v);
    logic [1:0] rs;
    axw(a, v, rs);
    chk(rs, RESP_OKAY);
  endtask
  // Status byte from the pins, timeout clear
  function automatic logic [31:0] exp_sts();
    return {24'h000000, !printer_busy, peripheral_interrupt, paper_end, printer_selected,
      printer_error_n, 3'b000};
  endfunction
  initial begin
    void'($urandom(27681));
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    chk(peripheral_reset_n, 0);
    axr(6'h24, d, r);
    chk(r, RESP_SLVERR); // Unmapped place
    axr(6'h10, d, r);
    chk(r, RESP_SLVERR);
    wrk(6'h08, 8'h24);
    repeat (2) @(posedge mclk);
    chk(port_data_oe, 0);
    chk(peripheral_reset_n, 1);
    axr(6'h08, d, r);
    chk(d, 32'h00000024);
    $display("test reset_map done");
    // Writes then reads on every port, both revisions
    for (int m = 1; m < 4; m += 2) begin
      wrk(6'h20, 8'(m));
      for (int k = 0; k < 10; k++) begin
        if (k % 5 == 0) wrk(6'h08, k < 5 ? 8'h04 : 8'h24);
        b = 8'($urandom);
        rd_byte <= 8'($urandom);
        dly <= (k % 5 == 4) ? 4'hf : 4'($urandom_range(0, 6));
        if (k < 5) begin
          axw(6'(12 + 4 * k), b, r);
          chk(got_byte, b);
          chk(port_data_out, b);
        end else begin
          axr(6'(4 * k - 8), d, r);
          chk(d, {24'h000000, rd_byte});
        end
        chk(r, RESP_OKAY);
        chk(got_addr, k % 5 == 0);
      end
      $display("test cycles rev %0d done", m);
    end
    // Revision 1.9 with wait high at the start; direction bit low for the read
    wrk(6'h08, 8'h04);
    arm_hold <= 1'b1;
    rd_byte <= 8'h5a;
    fork
      axr(6'h10, d, r);
      begin
        repeat (30) @(posedge mclk);
        chk(data_strobe_n, 1);
        chk(write_direction_n, 0);
        chk(port_data_oe, 1);
        arm_hold <= 1'b0;
      end
    join
    chk(d, 32'h0000005a);
    $display("test arm done");
    // Stalled peripheral in revision 1.7
    wrk(6'h20, 8'h01);
    wrk(6'h08, 8'h24);
    hang <= 1'b1;
    paper_end <= 1'($urandom);
    printer_selected <= 1'($urandom);
    printer_busy <= 1'($urandom);
    t0 = $time;
    axr(6'h14, d, r);
    chk(r, RESP_OKAY);
    chk(($time - t0) / 10 >= 1000 && ($time - t0) / 10 <= 1012, 1);
    hang <= 1'b0;
    axr(6'h04, d, r);
    chk(d[0], 1);
    wrk(6'h04, 8'h01);
    axr(6'h04, d, r);
    chk(d, exp_sts());
    $display("test watchdog done");
    // Interrupt pass-through
    wrk(6'h08, 8'h34);
    peripheral_interrupt <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(interrupt_out, 1);
    peripheral_interrupt <= 1'b0;
    repeat (5) @(posedge mclk);
    chk(interrupt_out, 0);
    $display("test interrupt done");
    end_of_test();
  end
endmodule
bind epp_cycle_engine epp_cycle_engine_properties i_epp_cycle_engine_properties (
  .mclk(mclk), .srst(srst), .data_strobe_n(data_strobe_n), .address_strobe_n(address_strobe_n),
  .write_direction_n(write_direction_n), .port_data_oe(port_data_oe),
  .port_data_out(port_data_out), .peripheral_wait_n(peripheral_wait_n),
  .peripheral_interrupt(peripheral_interrupt), .interrupt_out(interrupt_out),
  .peripheral_reset_n(peripheral_reset_n), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_rvalid(s_axi_rvalid)
);
